// ===== rtl/ewr_pkg.sv
// package: constants and types of the external write, wait and refresh block
package ewr_pkg;

   // register byte offsets
   localparam logic [4:0] A_CTRL = 5'h00;
   localparam logic [4:0] A_TIMING = 5'h04;
   localparam logic [4:0] A_STROBE = 5'h08;
   localparam logic [4:0] A_RFINT = 5'h0c;
   localparam logic [4:0] A_STATUS = 5'h10;

   // control bits
   localparam int C_EARLY = 0;
   localparam int C_RFEN = 1;

   // timing fields, each holds length minus one in half periods
   localparam int TM_T1 = 0;
   localparam int TM_T2 = 2;
   localparam int TM_T3 = 4;
   localparam int TM_T4 = 6;
   localparam int TM_T5 = 8;
   localparam int TM_T6 = 10;
   localparam logic [2:0] T6_MAX = 3'h4;

   // strobe delay fields
   localparam int SD_S1 = 0;
   localparam int SD_S2 = 5;
   localparam int SD_S3 = 10;
   localparam int SD_S4 = 15;

   // status fields
   localparam int ST_ROW = 0;
   localparam int ST_DUE = 16;
   localparam int ST_GNT = 17;
   localparam int ST_BUSY = 18;

   // sequencing counts
   localparam int ROW_W = 10;
   localparam logic [3:0] DUMMY_CNT = 4'h8;
   localparam logic [1:0] DUE_MIN = 2'h2;
   localparam logic [2:0] PRE_LEN = 3'h2;
   localparam logic [5:0] EL_MAX = 6'h3f;
   localparam logic [18:0] RF_AD_HIGH = 19'h7ffff;
   localparam logic [15:0] RFINT_DEF = 16'h0100;

   typedef enum logic [3:0] {
      S_IDLE, S_GNT, S_RPRE, S_T1, S_T2, S_T3,
      S_T4, S_TW, S_EW, S_T5, S_T6, S_T6A
   } ewr_st_t;

   typedef struct packed {
      logic early;
      logic rfen;
      logic [1:0] t1;
      logic [1:0] t2;
      logic [1:0] t3;
      logic [1:0] t4;
      logic [1:0] t5;
      logic [2:0] t6;
      logic [4:0] s1;
      logic [4:0] s2;
      logic [4:0] s3;
      logic [4:0] s4;
      logic [15:0] rfint;
   } ewr_cfg_t;

   localparam ewr_cfg_t CFG_RST = '{early: 1'b0, rfen: 1'b1,
      t1: 2'h0, t2: 2'h0, t3: 2'h0, t4: 2'h0, t5: 2'h0, t6: 3'h0,
      s1: 5'h1e, s2: 5'h01, s3: 5'h03, s4: 5'h05, rfint: RFINT_DEF};

   typedef struct packed {
      logic [31:0] ad;
      logic [3:0] ad_oe;
      logic d0;
      logic d0_oe;
      logic d1;
      logic d1_oe;
      logic [3:0] bws_n;
      logic rd_n;
      logic rf_n;
      logic [4:0] ps_n;
      logic due;
      logic gnt;
   } ewr_pins_t;

   localparam ewr_pins_t PINS_RST = '{ad: 32'h0, ad_oe: 4'h0,
      d0: 1'b1, d0_oe: 1'b0, d1: 1'b1, d1_oe: 1'b0, bws_n: 4'hf,
      rd_n: 1'b1, rf_n: 1'b1, ps_n: 5'h1f, due: 1'b0, gnt: 1'b0};

   typedef struct packed {
      logic clk_s1;
      logic clk_s2;
      logic clk_s3;
      logic wt_s1;
      logic wt_s2;
      logic br_s1;
      logic br_s2;
      logic wait_smp;
      ewr_st_t st;
      logic [2:0] cnt;
      logic [5:0] el;
      logic refr;
      logic quiet;
      logic ronly;
      logic [29:0] addr;
      logic [31:0] data;
      logic [3:0] be;
      logic due;
      logic [1:0] age;
      logic [15:0] ivl;
      logic [3:0] dummy;
      logic [ROW_W-1:0] row;
      logic ack;
      logic [31:0] rdat;
      ewr_cfg_t cfg;
      ewr_pins_t pin;
   } ewr_state_t;

endpackage : ewr_pkg

// ===== rtl/ewr_core.sv
// external memory write, wait-state and refresh sequencer with wishbone registers
`timescale 1ns/1ps
`default_nettype none

module ewr_core
   import ewr_pkg::*;
#(
   parameter logic [15:0] RFINT_RESET = RFINT_DEF
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic req_valid_i,
   input wire logic req_internal_i,
   input wire logic [29:0] req_addr_i,
   input wire logic [31:0] req_data_i,
   input wire logic [3:0] req_be_i,
   output logic req_ready_o,
   input wire logic processor_clock_output_i,
   input wire logic wait_request_i,
   input wire logic bus_request_i,
   output logic [31:0] mem_ad_o,
   output logic [3:0] mem_ad_oe_o,
   output logic write_indicator_data0_o,
   output logic write_indicator_data0_oe_o,
   output logic refresh_indicator_data1_o,
   output logic refresh_indicator_data1_oe_o,
   output logic [3:0] byte_write_strobe_n_o,
   output logic read_strobe_n_o,
   output logic refresh_strobe_n_o,
   output logic [4:0] programmable_strobes_n_o,
   output logic refresh_due_o,
   output logic bus_granted_o
);

   // a zero interval would refresh without pause
   if (RFINT_RESET == 16'h0) begin : g_bad_ivl
      $error("refresh interval reset value must be nonzero");
   end

   ewr_state_t q;
   ewr_state_t d;
   logic rise, fall, tick, idle, can_ext;
   logic rf_go, gnt_go, wr_go, wb_hit, mapped;
   logic [4:0] wb_off;

   // length of a state in half periods
   function automatic logic [2:0] len_of(input ewr_cfg_t c, input ewr_st_t s);
      logic [2:0] r;
      r = 3'h1;
      case (s)
         S_RPRE: r = PRE_LEN;
         S_T1: r = {1'b0, c.t1} + 3'h1;
         S_T2: r = {1'b0, c.t2} + 3'h1;
         S_T3: r = {1'b0, c.t3} + 3'h1;
         S_T4: r = {1'b0, c.t4} + 3'h1;
         S_T5: r = {1'b0, c.t5} + 3'h1;
         S_T6: r = c.t6 + 3'h1;
         default: r = 3'h1;
      endcase
      return r;
   endfunction : len_of

   // register readback
   function automatic logic [31:0] rdreg(input ewr_state_t s, input logic [4:0] a);
      logic [31:0] r;
      r = '0;
      case (a)
         A_CTRL: begin
            r[C_EARLY] = s.cfg.early;
            r[C_RFEN] = s.cfg.rfen;
         end
         A_TIMING: begin
            r[TM_T1+:2] = s.cfg.t1;
            r[TM_T2+:2] = s.cfg.t2;
            r[TM_T3+:2] = s.cfg.t3;
            r[TM_T4+:2] = s.cfg.t4;
            r[TM_T5+:2] = s.cfg.t5;
            r[TM_T6+:3] = s.cfg.t6;
         end
         A_STROBE: begin
            r[SD_S1+:5] = s.cfg.s1;
            r[SD_S2+:5] = s.cfg.s2;
            r[SD_S3+:5] = s.cfg.s3;
            r[SD_S4+:5] = s.cfg.s4;
         end
         A_RFINT: r[15:0] = s.cfg.rfint;
         A_STATUS: begin
            r[ST_ROW+:ROW_W] = s.row;
            r[ST_DUE] = s.due;
            r[ST_GNT] = s.st == S_GNT;
            r[ST_BUSY] = s.st != S_IDLE;
         end
         default: r = '0;
      endcase
      return r;
   endfunction : rdreg

   // byte-lane merge for partial writes
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8+:8] = n[i*8+:8];
         end
      end
      return r;
   endfunction : merge

   // half-period edges of the sampled processor clock
   assign rise = q.clk_s2 & ~q.clk_s3;
   assign fall = ~q.clk_s2 & q.clk_s3;
   assign tick = rise | fall;

   // cycle start decisions, taken on rising edges only
   assign idle = q.st == S_IDLE;
   assign can_ext = (q.dummy == 4'h0) & ~(q.due & q.cfg.rfen) & ~q.ronly;
   assign rf_go = idle & rise & ((q.dummy != 4'h0) |
                  (q.due & (q.age == DUE_MIN) & q.cfg.rfen));
   assign gnt_go = idle & rise & ~rf_go & q.br_s2;
   assign wr_go = idle & rise & ~rf_go & ~q.br_s2 & can_ext &
                  req_valid_i & ~req_internal_i;
   assign req_ready_o = req_valid_i & (req_internal_i | wr_go);

   // wishbone decode
   assign wb_hit = wb_cyc_i & wb_stb_i & ~q.ack;
   assign mapped = wb_adr_i[31:5] == 27'h0;
   assign wb_off = {wb_adr_i[4:2], 2'b00};

   // next-state of everything
   always_comb begin
      logic [31:0] wv;
      ewr_st_t nx;
      logic adv, ext, act, wr, rf, aph, dph, s25;
      wv = merge(rdreg(q, wb_off), wb_dat_i, wb_sel_i);
      nx = q.st;
      adv = 1'b0;
      {ext, act, wr, rf, aph, dph, s25} = 7'h0;
      d = q;

      // synchronisers
      {d.clk_s3, d.clk_s2, d.clk_s1} = {q.clk_s2, q.clk_s1, processor_clock_output_i};
      {d.wt_s2, d.wt_s1} = {q.wt_s1, wait_request_i};
      {d.br_s2, d.br_s1} = {q.br_s1, bus_request_i};
      if (fall) begin
         d.wait_smp = q.wt_s2;
      end

      // register access
      d.ack = wb_hit;
      if (wb_hit) begin
         d.rdat = mapped ? rdreg(q, wb_off) : 32'h0;
      end
      if (wb_cyc_i & wb_stb_i & q.ack & wb_we_i & mapped) begin // lands at the ack edge
         case (wb_off)
            A_CTRL: begin
               d.cfg.early = wv[C_EARLY];
               d.cfg.rfen = wv[C_RFEN];
            end
            A_TIMING: begin
               d.cfg.t1 = wv[TM_T1+:2];
               d.cfg.t2 = wv[TM_T2+:2];
               d.cfg.t3 = wv[TM_T3+:2];
               d.cfg.t4 = wv[TM_T4+:2];
               d.cfg.t5 = wv[TM_T5+:2];
               d.cfg.t6 = (wv[TM_T6+:3] > T6_MAX) ? T6_MAX : wv[TM_T6+:3];
            end
            A_STROBE: begin
               d.cfg.s1 = wv[SD_S1+:5];
               d.cfg.s2 = wv[SD_S2+:5];
               d.cfg.s3 = wv[SD_S3+:5];
               d.cfg.s4 = wv[SD_S4+:5];
            end
            A_RFINT: d.cfg.rfint = wv[15:0];
            default: d.cfg = q.cfg;
         endcase
      end

      // half-period counting inside a cycle
      ext = (q.st != S_IDLE) & (q.st != S_GNT);
      if (tick & ext) begin
         if (q.cnt != 3'h1) begin
            d.cnt = q.cnt - 3'h1;
         end else begin
            adv = 1'b1;
         end
         if (q.el != EL_MAX) begin
            d.el = q.el + 6'h1;
         end
      end

      // state order of one cycle
      if (adv) begin
         case (q.st)
            S_RPRE: nx = S_T1;
            S_T1: nx = S_T2;
            S_T2: nx = S_T3;
            S_T3: nx = S_T4;
            S_T4: nx = q.wait_smp ? S_TW : S_T5;
            S_TW: nx = q.wait_smp ? S_TW : (fall ? S_EW : S_T5);
            S_EW: nx = S_T5;
            S_T5: nx = S_T6;
            S_T6: nx = fall ? S_T6A : S_IDLE;
            default: nx = S_IDLE;
         endcase
         if ((nx == S_IDLE) & q.refr) begin
            if (q.quiet) begin
               d.dummy = q.dummy - 4'h1;
            end else begin
               d.row = q.row + 10'h1;
            end
         end
      end

      // cycle starts and bus release
      if (rf_go) begin
         nx = S_RPRE;
         d.refr = 1'b1;
         d.quiet = q.dummy != 4'h0;
         if (q.dummy == 4'h0) begin
            d.due = 1'b0;
         end
      end else if (gnt_go) begin
         nx = S_GNT;
         d.ronly = 1'b0;
      end else if (wr_go) begin
         nx = S_T1;
         d.refr = 1'b0;
         d.quiet = 1'b0;
         d.addr = req_addr_i;
         d.data = req_data_i;
         d.be = req_be_i;
      end else if ((q.st == S_GNT) & rise & ~q.br_s2) begin
         nx = S_IDLE;
         d.ronly = q.due & q.cfg.rfen;
      end
      if (nx != q.st) begin
         d.st = nx;
         d.cnt = len_of(q.cfg, nx);
         d.el = (nx == S_T2) ? 6'h0 : d.el;
      end

      // refresh interval timer, a new due beats its clearing
      if (tick & q.due & (q.age != DUE_MIN)) begin
         d.age = q.age + 2'h1;
      end
      if (tick & q.cfg.rfen & (q.dummy == 4'h0)) begin
         if (q.ivl <= 16'h1) begin
            d.ivl = q.cfg.rfint;
            d.age = d.due ? d.age : 2'h0;
            d.due = 1'b1;
         end else begin
            d.ivl = q.ivl - 16'h1;
         end
      end

      // pin values for the state being entered
      ext = (d.st != S_IDLE) & (d.st != S_GNT);
      act = ext & ~d.quiet;
      wr = act & ~d.refr;
      rf = act & d.refr;
      aph = ((d.st == S_RPRE) & (d.cnt == 3'h1)) | (d.st == S_T1) | (d.st == S_T2);
      dph = (d.st == S_T3) | (d.st == S_T4) | (d.st == S_TW) | (d.st == S_EW) |
            (d.st == S_T5) | (d.st == S_T6) | (d.st == S_T6A);
      s25 = (d.st == S_T2) | (d.st == S_T3) | (d.st == S_T4) | (d.st == S_TW) |
            (d.st == S_EW) | (d.st == S_T5);
      d.pin = PINS_RST;
      if (rf & aph) begin
         d.pin.ad = {1'b0, RF_AD_HIGH, d.row, 2'b00};
         d.pin.ad_oe = 4'hf;
      end else if (wr & aph) begin
         d.pin.ad = {d.addr, 2'b00};
         d.pin.ad_oe = 4'hf;
      end else if (wr & dph) begin
         d.pin.ad = d.data;
         d.pin.ad_oe = d.be;
      end
      if (wr & ((d.st == S_T1) | (d.st == S_T2))) begin
         d.pin.d0 = 1'b0;
         d.pin.d0_oe = 1'b1;
         d.pin.d1_oe = 1'b1;
      end
      if (rf & (aph | (d.st == S_RPRE))) begin
         d.pin.d1 = 1'b0;
         d.pin.d1_oe = 1'b1;
         d.pin.d0 = 1'b1;
         d.pin.d0_oe = 1'b1;
      end
      if (wr & ((d.st == S_T4) | (d.st == S_TW) | (d.st == S_EW) |
                (d.st == S_T5) | (d.cfg.early & (d.st == S_T3)))) begin
         d.pin.bws_n = ~d.be;
      end
      if (rf & (aph | (s25 & (d.st != S_T2)) | (d.st == S_T6))) begin
         d.pin.rf_n = 1'b0;
      end
      if (act) begin
         d.pin.ps_n[0] = ~s25;
         d.pin.ps_n[1] = ~((s25 | (d.st == S_T6)) & (d.el < {1'b0, d.cfg.s1}));
         d.pin.ps_n[2] = ~(s25 & (d.cfg.s2 != 5'h0) & (d.el >= {1'b0, d.cfg.s2}));
         d.pin.ps_n[3] = ~(s25 & (d.cfg.s3 != 5'h0) & (d.el >= {1'b0, d.cfg.s3}));
         d.pin.ps_n[4] = ~(s25 & (d.cfg.s4 != 5'h0) & (d.el >= {1'b0, d.cfg.s4}));
      end
      d.pin.due = d.due;
      d.pin.gnt = d.st == S_GNT;
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.cfg <= CFG_RST;
         q.cfg.rfint <= RFINT_RESET;
         q.ivl <= RFINT_RESET;
         q.dummy <= DUMMY_CNT;
         q.cnt <= 3'h1;
         q.pin <= PINS_RST;
      end else begin
         q <= d;
      end
   end

   // outputs straight from flip-flops
   assign wb_ack_o = q.ack;
   assign wb_dat_o = q.rdat;
   assign {mem_ad_o, mem_ad_oe_o, write_indicator_data0_o, write_indicator_data0_oe_o,
           refresh_indicator_data1_o, refresh_indicator_data1_oe_o, byte_write_strobe_n_o,
           read_strobe_n_o, refresh_strobe_n_o, programmable_strobes_n_o, refresh_due_o,
           bus_granted_o} = q.pin;

endmodule : ewr_core

`default_nettype wire

// ===== dv/ewr_core_asserts.sv
// pin-level assertion checker for the write, wait and refresh sequencer
`timescale 1ns/1ps
`default_nettype none
module ewr_core_asserts (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [31:0] mem_ad_o,
   input wire logic [3:0] mem_ad_oe_o,
   input wire logic write_indicator_data0_o,
   input wire logic write_indicator_data0_oe_o,
   input wire logic refresh_indicator_data1_o,
   input wire logic refresh_indicator_data1_oe_o,
   input wire logic [4:0] programmable_strobes_n_o,
   input wire logic [3:0] byte_write_strobe_n_o,
   input wire logic read_strobe_n_o,
   input wire logic refresh_strobe_n_o,
   input wire logic refresh_due_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // start of a write address phase, and start of the write strobes
   sequence s_wr_start;
      $fell(write_indicator_data0_o) ##0 write_indicator_data0_oe_o;
   endsequence
   sequence s_strobe_on;
      $rose(byte_write_strobe_n_o != 4'hf);
   endsequence
   chk_wr_ind_low: assert property (s_wr_start |-> !write_indicator_data0_o [*8])
      else $error("write indicator rose inside the address phase");
   chk_strobe_width: assert property (s_strobe_on |-> (byte_write_strobe_n_o != 4'hf) [*8])
      else $error("write strobe shorter than two half periods");
   chk_lane_float: assert property ((byte_write_strobe_n_o != 4'hf) |->
      mem_ad_oe_o == ~byte_write_strobe_n_o)
      else $error("lane drive does not follow the byte strobes");
   chk_data_hold: assert property ($rose(&byte_write_strobe_n_o) |->
      $stable({mem_ad_o, mem_ad_oe_o}) [*4])
      else $error("write data changed inside the hold state");
   chk_due_min: assert property ($rose(refresh_due_o) |-> refresh_due_o [*6])
      else $error("refresh due pulse too short");
   chk_due_clear: assert property ($fell(refresh_due_o) |-> ##[0:2] !refresh_indicator_data1_o)
      else $error("refresh due dropped without a refresh");
   chk_rf_order: assert property ($fell(refresh_strobe_n_o) |->
      !$past(refresh_indicator_data1_o) && write_indicator_data0_o)
      else $error("refresh indicators out of order");
   chk_rf_ind_drive: assert property (!refresh_indicator_data1_o |->
      refresh_indicator_data1_oe_o)
      else $error("refresh indicator low while undriven");
   chk_rf_s0: assert property ($fell(refresh_strobe_n_o) |->
      ##[1:24] !programmable_strobes_n_o[0])
      else $error("no fixed strobe in a refresh cycle");
   chk_rf_addr: assert property (!refresh_strobe_n_o && mem_ad_oe_o == 4'hf |->
      mem_ad_o[31:12] == 20'h7ffff)
      else $error("refresh address upper lines wrong");
   chk_rf_no_rw: assert property (!refresh_strobe_n_o |->
      read_strobe_n_o && byte_write_strobe_n_o == 4'hf)
      else $error("read or write strobe active in refresh");
endmodule : ewr_core_asserts
bind ewr_core ewr_core_asserts u_ewr_core_asserts (.clk_i(clk_i), .rst_i(rst_i),
   .mem_ad_o(mem_ad_o), .mem_ad_oe_o(mem_ad_oe_o),
   .write_indicator_data0_o(write_indicator_data0_o),
   .write_indicator_data0_oe_o(write_indicator_data0_oe_o),
   .refresh_indicator_data1_o(refresh_indicator_data1_o),
   .refresh_indicator_data1_oe_o(refresh_indicator_data1_oe_o),
   .programmable_strobes_n_o(programmable_strobes_n_o),
   .byte_write_strobe_n_o(byte_write_strobe_n_o), .read_strobe_n_o(read_strobe_n_o),
   .refresh_strobe_n_o(refresh_strobe_n_o), .refresh_due_o(refresh_due_o));
`default_nettype wire

// ===== dv/ewr_mem_model.sv
// memory partner: makes the processor clock, adds waits, latches writes and refreshes
`timescale 1ns/1ps
`default_nettype none
module ewr_mem_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] wait_len_i,
   input wire logic [31:0] ad_i,
   input wire logic wr_ind_i,
   input wire logic wr_ind_oe_i,
   input wire logic [3:0] bws_n_i,
   input wire logic rf_n_i,
   input wire logic s4_n_i,
   output logic pclk_o,
   output logic wait_o,
   output logic [7:0] wr_cnt_o,
   output logic [7:0] rf_cnt_o,
   output logic [7:0] low_o,
   output logic [29:0] addr_o,
   output logic [31:0] data_o,
   output logic [9:0] row_o
);
   logic [3:0] bws_q;
   logic rf_q;
   logic [7:0] run;
   // free-running processor clock, phase offset from the block clock
   initial begin
      pclk_o = 1'b0;
      #7;
      forever #160 pclk_o = ~pclk_o;
   end
   // wait raised on strobe four falling, held for a set number of rising clock edges
   initial begin
      wait_o = 1'b0;
      forever begin
         @(negedge s4_n_i);
         if (wait_len_i != 4'h0) begin
            wait_o <= 1'b1;
            repeat (wait_len_i) @(posedge pclk_o);
            wait_o <= 1'b0;
         end
      end
   end
   // address in the address phase, lane data on the strobe's rising edge, refresh row
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bws_q <= 4'hf;
         rf_q <= 1'b1;
         run <= 8'h0;
         wr_cnt_o <= 8'h0;
         rf_cnt_o <= 8'h0;
         low_o <= 8'h0;
         addr_o <= 30'h0;
         data_o <= 32'h0;
         row_o <= 10'h0;
      end else begin
         bws_q <= bws_n_i;
         rf_q <= rf_n_i;
         run <= (bws_n_i != 4'hf) ? run + 8'h1 : 8'h0;
         if (wr_ind_oe_i && !wr_ind_i) begin
            addr_o <= ad_i[31:2];
         end
         for (int i = 0; i < 4; i++) begin
            if (!bws_q[i] && bws_n_i[i]) begin
               data_o[i*8 +: 8] <= ad_i[i*8 +: 8];
            end
         end
         if (bws_q != 4'hf && bws_n_i == 4'hf) begin
            wr_cnt_o <= wr_cnt_o + 8'h1;
            low_o <= run;
         end
         if (rf_q && !rf_n_i) begin
            rf_cnt_o <= rf_cnt_o + 8'h1;
            row_o <= ad_i[11:2];
         end
      end
   end
endmodule : ewr_mem_model
`default_nettype wire

// ===== dv/tb_top.sv
// self-checking bench for the write, wait and refresh sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [31:0] RADR [5] = '{32'h0, 32'h4, 32'h8, 32'hc, 32'h100};
   localparam logic [31:0] RVAL [5] = '{32'h2, 32'h0, 32'h28c3e, 32'h20, 32'h0};
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [31:0] adr = 32'h0;
   logic [31:0] wdat = 32'h0;
   logic rv = 1'b0;
   logic rint = 1'b0;
   logic [29:0] raddr = 30'h0;
   logic [31:0] rdat = 32'h0;
   logic [3:0] rbe = 4'h0;
   logic breq = 1'b0;
   logic [3:0] wait_len = 4'h0;
   logic [31:0] wb_dat_o, ad;
   logic [3:0] ad_oe, bws;
   logic [4:0] ps;
   logic ack, rdy, pclk, wreq, d0, d0_oe, d1, d1_oe, rd_n, rf_n, due, gnt;
   logic [7:0] wr_cnt, rf_cnt, low, wr_exp, rf_exp;
   logic [29:0] laddr;
   logic [31:0] ldata;
   logic [9:0] row;
   int miscompares = 0;
   int total_checks = 0;
   // block clock
   always #20 clk_i = ~clk_i;
   ewr_core #(.RFINT_RESET(16'h0020)) u_ewr_core (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
      .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(ack), .req_valid_i(rv),
      .req_internal_i(rint), .req_addr_i(raddr), .req_data_i(rdat), .req_be_i(rbe),
      .req_ready_o(rdy), .processor_clock_output_i(pclk), .wait_request_i(wreq),
      .bus_request_i(breq), .mem_ad_o(ad), .mem_ad_oe_o(ad_oe),
      .write_indicator_data0_o(d0), .write_indicator_data0_oe_o(d0_oe),
      .refresh_indicator_data1_o(d1), .refresh_indicator_data1_oe_o(d1_oe),
      .byte_write_strobe_n_o(bws), .read_strobe_n_o(rd_n), .refresh_strobe_n_o(rf_n),
      .programmable_strobes_n_o(ps), .refresh_due_o(due), .bus_granted_o(gnt));
   ewr_mem_model u_ewr_mem_model (.clk_i(clk_i), .rst_i(rst_i), .wait_len_i(wait_len),
      .ad_i(ad), .wr_ind_i(d0), .wr_ind_oe_i(d0_oe), .bws_n_i(bws), .rf_n_i(rf_n),
      .s4_n_i(ps[4]), .pclk_o(pclk), .wait_o(wreq), .wr_cnt_o(wr_cnt), .rf_cnt_o(rf_cnt),
      .low_o(low), .addr_o(laddr), .data_o(ldata), .row_o(row));
   // verdict and end of run
   task automatic close_out();
      if (miscompares == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : close_out
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : check
   function automatic logic cond(input int c);
      case (c)
         0: return due === 1'b1;
         1: return gnt === 1'b1;
         2: return gnt === 1'b0;
         3: return wr_cnt === wr_exp;
         default: return rf_cnt === rf_exp;
      endcase
   endfunction : cond
   // bounded wait on one of the conditions above
   task automatic await(input int c);
      int n;
      n = 0;
      while (!cond(c)) begin
         @(posedge clk_i);
         n++;
         if (n > 5000) begin
            miscompares++;
            close_out();
         end
      end
   endtask : await
   // one classic wishbone cycle, held until ack
   task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         miscompares++;
         close_out();
      end
      q = wb_dat_o;
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   // one memory request, held until ready
   task automatic mem_wr(input logic i, input logic [29:0] a, input logic [31:0] d,
      input logic [3:0] be);
      int n;
      rv <= 1'b1;
      rint <= i;
      raddr <= a;
      rdat <= d;
      rbe <= be;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (rdy !== 1'b1 && n < 5000);
      if (n >= 5000) begin
         miscompares++;
         close_out();
      end
      rv <= 1'b0;
      @(posedge clk_i);
   endtask : mem_wr
   // main sequence
   initial begin
      logic [31:0] q;
      logic [9:0] r0;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int i = 0; i < 5; i++) begin
         wb(1'b0, RADR[i], 32'h0, q);
         check(q, RVAL[i]);
      end
      wb(1'b1, 32'h8, 32'h8c3e, q);
      wb(1'b0, 32'h8, 32'h0, q);
      check(q, 32'h8c3e);
      // internal access leaves the bus alone, then a late write on lanes 0 and 2
      mem_wr(1'b1, 30'h15, 32'hffffffff, 4'hf);
      mem_wr(1'b0, 30'h0123456, 32'ha1b2c3d4, 4'h5);
      wr_exp = 8'h1;
      await(3);
      check(ldata, 32'h00b200d4);
      check({2'h0, laddr}, 32'h0123456);
      check({24'h0, low}, 32'h8);
      // early write with a two half period T3
      wb(1'b1, 32'h0, 32'h3, q);
      wb(1'b1, 32'h4, 32'h10, q);
      mem_wr(1'b0, 30'h2aaaa, 32'h5a5aa5a5, 4'hf);
      wr_exp = 8'h2;
      await(3);
      check(ldata, 32'h5a5aa5a5);
      check({24'h0, low}, 32'h10);
      // late write with a four half period T4 stretched by waits
      wb(1'b1, 32'h0, 32'h2, q);
      wb(1'b1, 32'h4, 32'hc0, q);
      wait_len <= 4'h3;
      mem_wr(1'b0, 30'h3c, 32'h0f0f0f0f, 4'hf);
      wr_exp = 8'h3;
      await(3);
      wait_len <= 4'h0;
      check({31'h0, low > 8'h14}, 32'h1);
      check({29'h0, low[2:0]}, 32'h0);
      // two refreshes step the row counter by one
      rf_exp = rf_cnt + 8'h1;
      await(4);
      r0 = row;
      rf_exp = rf_cnt + 8'h1;
      await(4);
      check({22'h0, row}, {22'h0, r0 + 10'h1});
      // bus hand-over: due shows while granted, refresh waits for the release
      breq <= 1'b1;
      await(1);
      rf_exp = rf_cnt;
      await(0);
      check({24'h0, rf_cnt}, {24'h0, rf_exp});
      check({31'h0, gnt}, 32'h1);
      rf_exp = rf_cnt + 8'h1;
      breq <= 1'b0;
      await(4);
      breq <= 1'b1;
      await(1);
      breq <= 1'b0;
      await(2);
      // refresh switched off just after a refresh starts
      rf_exp = rf_cnt + 8'h1;
      await(4);
      wb(1'b1, 32'h0, 32'h0, q);
      rf_exp = rf_cnt;
      repeat (600) @(posedge clk_i);
      check({24'h0, rf_cnt}, {24'h0, rf_exp});
      close_out();
   end
endmodule : tb_top
`default_nettype wire
